// ---- cfm_addon.sv ----
// add-on channels: staggered switch-on and per-channel fuse indication
`timescale 1ns/1ps
module cfm_addon (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  cfm_tick_if.snk                       tb,
  input  wire logic                     seq_start,
  input  wire logic [cfm_pkg::NCH-1:0]  ch_fuse_ok,
  output logic      [cfm_pkg::NCH-1:0]  ch_on,
  output logic      [cfm_pkg::NCH-1:0]  ch_green_led,
  output logic                          red_led,
  output logic                          addon_relay,
  output logic                          addon_fault
);

  logic [cfm_pkg::NCH-1:0] on_r;
  logic [cfm_pkg::NCH-1:0] on_nxt;
  logic [cfm_pkg::NCH-1:0] grn_r;
  logic [cfm_pkg::NCH-1:0] grn_nxt;
  logic                    blown;
  logic                    red_r;
  logic                    rel_r;

  assign blown = ~&ch_fuse_ok;

  // one more channel per 100 ms so inrush peaks never coincide
  always_comb begin
    on_nxt = on_r;
    if (!seq_start) begin
      on_nxt = '0;
    end else if (tb.tick_100ms) begin
      on_nxt = {on_r[cfm_pkg::NCH-2:0], 1'b1};
    end
  end

  genvar g;
  generate
    for (g = 0; g < cfm_pkg::NCH; g++) begin : g_ch
      always_comb begin
        grn_nxt[g] = on_r[g] & ch_fuse_ok[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      on_r  <= '0;
      grn_r <= '0;
      red_r <= 1'b0;
      rel_r <= 1'b0;
    end else begin
      on_r  <= on_nxt;
      grn_r <= grn_nxt;
      red_r <= blown;
      rel_r <= ~blown;
    end
  end

  assign ch_on        = on_r;
  assign ch_green_led = grn_r;
  assign red_led      = red_r;
  assign addon_relay  = rel_r;
  assign addon_fault  = red_r;

endmodule

// ---- cfm_monitor.sv ----
// collective fault monitor of a fire-system power supply
//
// Behaviour
// - mains-loss relay held closed with mains, opened after delay on loss
// - delay selectable 10 s, 1 min, 10 min, 30 min; both relays obey it
// - mains loss: mains LED off, fault LED blinks at once
// - mains return restores indicators and relays promptly
// - broken battery continuity flagged within 5 minutes, relay to fault
// - battery fault clears after next battery test
// - collective fault is OR of all fault conditions but charge limiting, with mains loss delayed
// - load output below 26 V or above 29.2 V is a fault
// - battery over 65 C fault; below -20 C or over 80 C sensor fault
// - open external fault input is a fault
// - open enclosure switch is a fault
// - overload limits charging 1 minute, repeated while overload stays
// - blown load fuse lights fault LED and asserts collective fault
// - add-on outputs switch on one after another every 100 ms
// - blown add-on fuse: LED off, red on, relay released, fault raised
// - relays energised in normal state, released means fault
// - load LEDs lit whenever their outputs carry voltage
// - external and enclosure inputs normal closed, fault open
// - battery test every 5 minutes feeds battery faults
`timescale 1ns/1ps
module cfm_monitor #(
  parameter int TICK_CYCLES = cfm_pkg::CYC_100MS
) (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // avalon-mm slave
  input  wire logic [3:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // pins, active high unless named otherwise
  input  wire logic                     mains_ok,
  input  wire logic                     battery_continuity_ok,
  input  wire logic                     battery_resistance_ok,
  input  wire logic                     battery_voltage_ok,
  input  wire logic                     battery_fault,
  input  wire logic                     charger_fault,
  input  wire logic                     first_output_fuse_ok,
  input  wire logic                     second_output_fuse_ok,
  input  wire logic                     overload,
  input  wire logic                     external_fault_input,
  input  wire logic                     tamper_closed,
  input  wire logic                     internal_fault,
  input  wire logic                     first_load_output,
  input  wire logic                     second_load_output,
  input  wire logic                     seq_start,
  input  wire logic [cfm_pkg::NCH-1:0]  ch_fuse_ok,
  // measurements from on-chip converters, same clock
  input  wire logic [15:0]              first_load_output_mv,
  input  wire logic [15:0]              second_load_output_mv,
  input  wire logic signed [7:0]        batt_temp_c,
  // outputs
  output logic                          mains_loss_relay,
  output logic                          fault_relay,
  output logic                          mains_led,
  output logic                          fault_led,
  output logic                          load1_led,
  output logic                          load2_led,
  output logic                          charge_limit,
  output logic      [cfm_pkg::NCH-1:0]  ch_on,
  output logic      [cfm_pkg::NCH-1:0]  ch_green_led,
  output logic                          addon_red_led,
  output logic                          addon_relay
);

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  logic [cfm_pkg::NPIN-1:0] pin_raw;
  logic [cfm_pkg::NPIN-1:0] pin_s1_r;
  logic [cfm_pkg::NPIN-1:0] pin_r;
  logic [cfm_pkg::NCH-1:0]  chf_s1_r;
  logic [cfm_pkg::NCH-1:0]  chf_r;
  logic                     seq_s1_r;
  logic                     seq_r;

  assign pin_raw = {second_load_output, first_load_output, internal_fault,
                    tamper_closed, external_fault_input, overload,
                    second_output_fuse_ok, first_output_fuse_ok,
                    charger_fault, battery_fault, battery_voltage_ok,
                    battery_resistance_ok, battery_continuity_ok, mains_ok};

  // ok-style pins reset to their healthy level so no fault flashes at start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 14'h36CF;
      pin_r    <= 14'h36CF;
      chf_s1_r <= 8'hFF;
      chf_r    <= 8'hFF;
      seq_s1_r <= 1'b0;
      seq_r    <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_r    <= pin_s1_r;
      chf_s1_r <= ch_fuse_ok;
      chf_r    <= chf_s1_r;
      seq_s1_r <= seq_start;
      seq_r    <= seq_s1_r;
    end
  end

  // ******************************************************
  // timebase and add-on
  // ******************************************************
  cfm_tick_if tb ();

  cfm_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tb (
    .mclk (mclk),
    .rstn (rstn),
    .tb   (tb)
  );

  logic addon_fault;

  cfm_addon u_addon (
    .mclk         (mclk),
    .rstn         (rstn),
    .tb           (tb),
    .seq_start    (seq_r),
    .ch_fuse_ok   (chf_r),
    .ch_on        (ch_on),
    .ch_green_led (ch_green_led),
    .red_led      (addon_red_led),
    .addon_relay  (addon_relay),
    .addon_fault  (addon_fault)
  );

  // ******************************************************
  // register bus
  // ******************************************************
  logic [1:0]  dly_sel_r;
  logic [1:0]  dly_sel_nxt;
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [cfm_pkg::NFLT-1:0] flt;

  // answer comes one cycle after the request; writes land on the edge after that
  always_comb begin
    wait_nxt    = 1'b1;
    rdata_nxt   = rdata_r;
    dly_sel_nxt = dly_sel_r;
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = 32'h00000000;
      if (avs_read && avs_address == cfm_pkg::REG_CTRL) begin
        rdata_nxt = {30'h00000000, dly_sel_r};
      end else if (avs_read && avs_address == cfm_pkg::REG_STATUS) begin
        rdata_nxt = {17'h00000, flt};
      end
    end
    if (avs_write && !wait_r && avs_address == cfm_pkg::REG_CTRL
        && avs_byteenable[0]) begin
      dly_sel_nxt = avs_writedata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_r    <= 1'b1;
      rdata_r   <= 32'h00000000;
      dly_sel_r <= cfm_pkg::CTRL_DLY_RST;
    end else begin
      wait_r    <= wait_nxt;
      rdata_r   <= rdata_nxt;
      dly_sel_r <= dly_sel_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  // ******************************************************
  // mains delay, battery test, overload limiter
  // ******************************************************
  logic [10:0] dly_lim;
  logic        mains_up;
  logic [10:0] mains_cnt_r;
  logic [10:0] mains_cnt_nxt;
  logic        mains_dly_r;
  logic        mains_dly_nxt;
  logic [10:0] bt_cnt_r;
  logic [10:0] bt_cnt_nxt;
  logic [2:0]  bt_res_r;
  logic [2:0]  bt_res_nxt;
  logic [10:0] ovl_cnt_r;
  logic [10:0] ovl_cnt_nxt;
  cfm_pkg::cfm_chg_t chg_r;
  cfm_pkg::cfm_chg_t chg_nxt;

  assign mains_up = pin_r[cfm_pkg::P_MAINS];

  always_comb begin
    unique case (dly_sel_r)
      2'h0: dly_lim = cfm_pkg::MAINS_DLY_10S_S;
      2'h1: dly_lim = cfm_pkg::MAINS_DLY_1M_S;
      2'h2: dly_lim = cfm_pkg::MAINS_DLY_10M_S;
      2'h3: dly_lim = cfm_pkg::MAINS_DLY_30M_S;
    endcase
  end

  always_comb begin
    mains_cnt_nxt = mains_cnt_r;
    mains_dly_nxt = mains_dly_r;
    if (mains_up) begin
      mains_cnt_nxt = 11'h000;
      mains_dly_nxt = 1'b0;
    end else if (tb.tick_1s && !mains_dly_r) begin
      mains_cnt_nxt = mains_cnt_r + 11'h001;
      if (mains_cnt_r + 11'h001 >= dly_lim) begin
        mains_dly_nxt = 1'b1;
      end
    end
  end

  // test is locked out on battery; first result after 5 min of mains
  always_comb begin
    bt_cnt_nxt = bt_cnt_r;
    bt_res_nxt = bt_res_r;
    if (!mains_up) begin
      bt_cnt_nxt = 11'h000;
    end else if (tb.tick_1s) begin
      bt_cnt_nxt = bt_cnt_r + 11'h001;
      if (bt_cnt_r + 11'h001 >= cfm_pkg::BATT_TEST_S) begin
        bt_cnt_nxt = 11'h000;
        bt_res_nxt = pin_r[cfm_pkg::P_BVOLT:cfm_pkg::P_BCONT];
      end
    end
  end

  always_comb begin
    chg_nxt     = chg_r;
    ovl_cnt_nxt = ovl_cnt_r;
    unique case (chg_r)
      cfm_pkg::CFM_CHG_NORMAL: begin
        ovl_cnt_nxt = 11'h000;
        if (pin_r[cfm_pkg::P_OVERLOAD]) begin
          chg_nxt = cfm_pkg::CFM_CHG_LIMIT;
        end
      end
      cfm_pkg::CFM_CHG_LIMIT: begin
        if (tb.tick_1s) begin
          ovl_cnt_nxt = ovl_cnt_r + 11'h001;
          if (ovl_cnt_r + 11'h001 >= cfm_pkg::OVL_LIMIT_S) begin
            ovl_cnt_nxt = 11'h000;
            if (!pin_r[cfm_pkg::P_OVERLOAD]) begin
              chg_nxt = cfm_pkg::CFM_CHG_NORMAL;
            end
          end
        end
      end
      default: begin
        chg_nxt = cfm_pkg::CFM_CHG_NORMAL;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mains_cnt_r <= 11'h000;
      mains_dly_r <= 1'b0;
      bt_cnt_r    <= 11'h000;
      bt_res_r    <= 3'h7;
      ovl_cnt_r   <= 11'h000;
      chg_r       <= cfm_pkg::CFM_CHG_NORMAL;
    end else begin
      mains_cnt_r <= mains_cnt_nxt;
      mains_dly_r <= mains_dly_nxt;
      bt_cnt_r    <= bt_cnt_nxt;
      bt_res_r    <= bt_res_nxt;
      ovl_cnt_r   <= ovl_cnt_nxt;
      chg_r       <= chg_nxt;
    end
  end

  // ******************************************************
  // fault gathering
  // ******************************************************
  always_comb begin
    flt = '0;
    flt[cfm_pkg::F_MAINS]     = !mains_up;
    flt[cfm_pkg::F_MAINS_DLY] = mains_dly_r;
    flt[cfm_pkg::F_BTEST]     = ~&bt_res_r;
    flt[cfm_pkg::F_BATT]      = pin_r[cfm_pkg::P_BFAULT];
    flt[cfm_pkg::F_CHARGER]   = pin_r[cfm_pkg::P_CHARGER];
    flt[cfm_pkg::F_AUXV]      = first_load_output_mv < cfm_pkg::AUX_MIN_MV
                              || first_load_output_mv > cfm_pkg::AUX_MAX_MV
                              || second_load_output_mv < cfm_pkg::AUX_MIN_MV
                              || second_load_output_mv > cfm_pkg::AUX_MAX_MV;
    flt[cfm_pkg::F_FUSE]      = !pin_r[cfm_pkg::P_FUSE1]
                              || !pin_r[cfm_pkg::P_FUSE2];
    flt[cfm_pkg::F_OVERLOAD]  = pin_r[cfm_pkg::P_OVERLOAD];
    flt[cfm_pkg::F_TEMP]      = batt_temp_c > cfm_pkg::TEMP_HI_C;
    flt[cfm_pkg::F_SENSOR]    = batt_temp_c < cfm_pkg::SENSOR_LO_C
                              || batt_temp_c > cfm_pkg::SENSOR_HI_C;
    flt[cfm_pkg::F_EXT]       = !pin_r[cfm_pkg::P_EXT];
    flt[cfm_pkg::F_TAMPER]    = !pin_r[cfm_pkg::P_TAMPER];
    flt[cfm_pkg::F_INTERNAL]  = pin_r[cfm_pkg::P_INTERNAL];
    flt[cfm_pkg::F_ADDON]     = addon_fault;
    flt[cfm_pkg::F_CHGLIM]    = chg_r == cfm_pkg::CFM_CHG_LIMIT;
  end

  // ******************************************************
  // indicators and relays
  // ******************************************************
  logic any_now;
  logic any_relay;
  logic blink_r;
  logic blink_nxt;
  logic [6:0] out_r;
  logic [6:0] out_nxt;

  // LED reacts at once; relay waits for the delay on mains loss only
  assign any_now   = |flt[cfm_pkg::F_ADDON:cfm_pkg::F_BTEST] || !mains_up;
  assign any_relay = |flt[cfm_pkg::F_ADDON:cfm_pkg::F_BTEST]
                   || mains_dly_r;

  always_comb begin
    blink_nxt = blink_r;
    if (!any_now) begin
      blink_nxt = 1'b0;
    end else if (tb.tick_1s) begin
      blink_nxt = !blink_r;
    end
    out_nxt[0] = !mains_dly_r;
    out_nxt[1] = !any_relay;
    out_nxt[2] = mains_up;
    out_nxt[3] = any_now && !blink_r;
    out_nxt[4] = pin_r[cfm_pkg::P_LOAD1];
    out_nxt[5] = pin_r[cfm_pkg::P_LOAD2];
    out_nxt[6] = chg_r == cfm_pkg::CFM_CHG_LIMIT;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      blink_r <= 1'b0;
      out_r   <= 7'h00;
    end else begin
      blink_r <= blink_nxt;
      out_r   <= out_nxt;
    end
  end

  assign mains_loss_relay = out_r[0];
  assign fault_relay      = out_r[1];
  assign mains_led        = out_r[2];
  assign fault_led        = out_r[3];
  assign load1_led        = out_r[4];
  assign load2_led        = out_r[5];
  assign charge_limit     = out_r[6];

endmodule

// ---- cfm_monitor_props.sv ----
// concurrent checks on the collective fault monitor ports
`timescale 1ns/1ps
module cfm_monitor_chk (
  input wire logic                    mclk,
  input wire logic                    rstn,
  input wire logic                    mains_ok,
  input wire logic                    first_output_fuse_ok,
  input wire logic                    overload,
  input wire logic                    external_fault_input,
  input wire logic                    tamper_closed,
  input wire logic                    first_load_output,
  input wire logic [cfm_pkg::NCH-1:0] ch_fuse_ok,
  input wire logic                    mains_loss_relay,
  input wire logic                    fault_relay,
  input wire logic                    mains_led,
  input wire logic                    fault_led,
  input wire logic                    load1_led,
  input wire logic                    charge_limit,
  input wire logic [cfm_pkg::NCH-1:0] ch_on,
  input wire logic                    addon_red_led,
  input wire logic                    addon_relay
);
  // ********
  // mains-loss duration
  // ********
  logic [11:0] low_r;
  logic [11:0] low_nxt;
  // saturates so a long outage never wraps back under the bound
  always_comb begin
    low_nxt = low_r;
    if (mains_ok) begin
      low_nxt = 12'h000;
    end else if (low_r != 12'hFFF) begin
      low_nxt = low_r + 12'h001;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      low_r <= 12'h000;
    end else begin
      low_r <= low_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ********
  // assertions
  // ********
  a_mains_led_off: assert property (!mains_ok [*4] |-> !mains_led)
    else $error("mains led lit without mains");
  a_fault_led_now: assert property ($fell(mains_ok) |-> ##[1:4] fault_led)
    else $error("fault led late after mains loss");
  a_relay_hold: assert property (mains_ok [*5] |-> mains_loss_relay)
    else $error("mains relay open with mains");
  a_relay_early: assert property ($fell(mains_loss_relay) |-> low_r >= 12'h320)
    else $error("mains relay opened before delay");
  a_ext_open: assert property (!external_fault_input [*4] |-> !fault_relay)
    else $error("open external input not reported");
  a_tamper_open: assert property (!tamper_closed [*4] |-> !fault_relay)
    else $error("open enclosure not reported");
  a_fuse_blown: assert property (!first_output_fuse_ok [*4] |-> !fault_relay)
    else $error("blown output fuse not reported");
  a_load_led: assert property (first_load_output [*4] |-> load1_led)
    else $error("load led dark with output live");
  a_charge_lim: assert property (overload [*5] |-> charge_limit)
    else $error("no charge limiting on overload");
  a_seq_gap: assert property ($rose(ch_on[0]) |=> !ch_on[1] [*8])
    else $error("second channel switched too soon");
  a_addon_fuse: assert property ((!(&ch_fuse_ok)) [*4] |-> addon_red_led && !addon_relay)
    else $error("add-on fuse fault not shown");
  c_mains_open: cover property ($fell(mains_loss_relay));
  c_seq_full: cover property ($rose(ch_on[7]));
  c_limit_end: cover property ($fell(charge_limit));
endmodule
bind cfm_monitor cfm_monitor_chk chk_u (.*);

// ---- cfm_panel.sv ----
// fire panel model reading the relay contacts of the monitor
`timescale 1ns/1ps
module cfm_panel (
  input  wire logic mclk,
  input  wire logic mains_loss_relay,
  input  wire logic fault_relay,
  input  wire logic ext_open,
  output logic      mains_alarm,
  output logic      collective_alarm,
  output logic      external_fault_input
);
  // a released contact reads as alarm, so a dead supply alarms too
  always_ff @(posedge mclk) begin
    mains_alarm      <= !mains_loss_relay;
    collective_alarm <= !fault_relay;
  end
  // open-collector stage: opening the loop signals a fault
  assign external_fault_input = !ext_open;
endmodule

// ---- cfm_pkg.sv ----
// constants, field positions and types of the collective fault monitor
package cfm_pkg;

  // ******************************************************
  // timing
  // ******************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEQ_GAP_MS    = 100;
  localparam int CYC_100MS     = SEQ_GAP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_MS       = 100;
  localparam logic [3:0] TICKS_PER_S = 4'(1000 / TICK_MS);

  localparam logic [10:0] MAINS_DLY_10S_S = 11'h00A;
  localparam logic [10:0] MAINS_DLY_1M_S  = 11'h03C;
  localparam logic [10:0] MAINS_DLY_10M_S = 11'h258;
  localparam logic [10:0] MAINS_DLY_30M_S = 11'h708;
  localparam logic [10:0] BATT_TEST_S     = 11'h12C;
  localparam logic [10:0] OVL_LIMIT_S     = 11'h03C;

  // ******************************************************
  // thresholds
  // ******************************************************
  localparam logic [15:0] AUX_MIN_MV     = 16'h6590;
  localparam logic [15:0] AUX_MAX_MV     = 16'h7210;
  localparam logic signed [7:0] TEMP_HI_C     = 8'sh41;
  localparam logic signed [7:0] SENSOR_LO_C   = -8'sh14;
  localparam logic signed [7:0] SENSOR_HI_C   = 8'sh50;

  // ******************************************************
  // pin vector positions
  // ******************************************************
  localparam int NPIN        = 14;
  localparam int P_MAINS     = 0;
  localparam int P_BCONT     = 1;
  localparam int P_BRES      = 2;
  localparam int P_BVOLT     = 3;
  localparam int P_BFAULT    = 4;
  localparam int P_CHARGER   = 5;
  localparam int P_FUSE1     = 6;
  localparam int P_FUSE2     = 7;
  localparam int P_OVERLOAD  = 8;
  localparam int P_EXT       = 9;
  localparam int P_TAMPER    = 10;
  localparam int P_INTERNAL  = 11;
  localparam int P_LOAD1     = 12;
  localparam int P_LOAD2     = 13;

  localparam int NCH = 8;

  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [1:0] CTRL_DLY_RST = 2'h0;

  localparam int NFLT        = 15;
  localparam int F_MAINS     = 0;
  localparam int F_MAINS_DLY = 1;
  localparam int F_BTEST     = 2;
  localparam int F_BATT      = 3;
  localparam int F_CHARGER   = 4;
  localparam int F_AUXV      = 5;
  localparam int F_FUSE      = 6;
  localparam int F_OVERLOAD  = 7;
  localparam int F_TEMP      = 8;
  localparam int F_SENSOR    = 9;
  localparam int F_EXT       = 10;
  localparam int F_TAMPER    = 11;
  localparam int F_INTERNAL  = 12;
  localparam int F_ADDON     = 13;
  localparam int F_CHGLIM    = 14;

  typedef enum logic [1:0] {
    CFM_CHG_NORMAL = 2'b01,
    CFM_CHG_LIMIT  = 2'b10
  } cfm_chg_t;

endpackage

// ---- cfm_tick_if.sv ----
// timebase strobes shared between the monitor's modules
`timescale 1ns/1ps
interface cfm_tick_if;
  logic tick_100ms;
  logic tick_1s;
  modport src (output tick_100ms, output tick_1s);
  modport snk (input tick_100ms, input tick_1s);
endinterface

// ---- cfm_timebase.sv ----
// divider producing 100 ms and 1 s enable pulses
`timescale 1ns/1ps
module cfm_timebase #(
  parameter int TICK_CYCLES = cfm_pkg::CYC_100MS
) (
  input  wire logic   mclk,
  input  wire logic   rstn,
  cfm_tick_if.src     tb
);

  logic [23:0] div_r;
  logic [23:0] div_nxt;
  logic [3:0]  sub_r;
  logic [3:0]  sub_nxt;
  logic        t100_r;
  logic        t100_nxt;
  logic        t1s_r;
  logic        t1s_nxt;

  always_comb begin
    div_nxt  = div_r + 24'h000001;
    sub_nxt  = sub_r;
    t100_nxt = 1'b0;
    t1s_nxt  = 1'b0;
    if (div_r == 24'(TICK_CYCLES - 1)) begin
      div_nxt  = 24'h000000;
      t100_nxt = 1'b1;
      sub_nxt  = sub_r + 4'h1;
      if (sub_r == cfm_pkg::TICKS_PER_S - 4'h1) begin
        sub_nxt = 4'h0;
        t1s_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_r  <= 24'h000000;
      sub_r  <= 4'h0;
      t100_r <= 1'b0;
      t1s_r  <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      sub_r  <= sub_nxt;
      t100_r <= t100_nxt;
      t1s_r  <= t1s_nxt;
    end
  end

  assign tb.tick_100ms = t100_r;
  assign tb.tick_1s    = t1s_r;

endmodule

// ---- test_collective_fault_monitor.sv ----
// self-checking bench of the collective fault monitor
`timescale 1ns/1ps
module test_collective_fault_monitor;
  // ********
  // signals
  // ********
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        mains_ok = 1'b1, battery_continuity_ok = 1'b1;
  logic        battery_resistance_ok = 1'b1, battery_voltage_ok = 1'b1;
  logic        battery_fault = 1'b0, charger_fault = 1'b0;
  logic        first_output_fuse_ok = 1'b1, second_output_fuse_ok = 1'b1;
  logic        overload = 1'b0, tamper_closed = 1'b1, internal_fault = 1'b0;
  logic        first_load_output = 1'b1, second_load_output = 1'b1;
  logic        seq_start = 1'b0, ext_open = 1'b0, external_fault_input;
  logic [7:0]  ch_fuse_ok = 8'hFF, ch_on, ch_green_led;
  logic [15:0] first_load_output_mv = 16'h6D60, second_load_output_mv = 16'h6D60;
  logic signed [7:0] batt_temp_c = 8'sh19;
  logic        mains_loss_relay, fault_relay, mains_led, fault_led;
  logic        load1_led, load2_led, charge_limit, addon_red_led;
  logic        addon_relay, mains_alarm, collective_alarm;
  int          num_errors = 0;
  int          checks = 0;

  always #5 mclk = ~mclk;
  // one second is 100 cycles with this tick
  cfm_monitor #(.TICK_CYCLES(10)) dut_u (.*);
  cfm_panel panel_u (.*);

  // ********
  // helpers
  // ********
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) num_errors++;
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic apply(int i, logic f);
    case (i)
      0: charger_fault <= f;
      1: battery_fault <= f;
      2: first_output_fuse_ok <= !f;
      3: second_output_fuse_ok <= !f;
      4: ext_open <= f;
      5: tamper_closed <= !f;
      6: internal_fault <= f;
      7: first_load_output_mv <= f ? 16'h658F : 16'h6590;
      8: second_load_output_mv <= f ? 16'h7211 : 16'h7210;
      9: batt_temp_c <= f ? 8'sh42 : 8'sh41;
      10: batt_temp_c <= f ? -8'sh15 : -8'sh14;
      default: batt_temp_c <= f ? 8'sh51 : 8'sh19;
    endcase
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_regs();
    int i;
    chk("relays", {mains_loss_relay, fault_relay}, 3);
    chk("load leds", {load1_led, load2_led}, 3);
    bus(1'b1, cfm_pkg::REG_STATUS, 32'hFFFF);
    bus(1'b0, cfm_pkg::REG_STATUS, 0);
    chk("status", q, 0);
    bus(1'b0, 4'h8, 0);
    chk("unmapped", q, 0);
    for (i = 3; i >= 0; i--) begin
      bus(1'b1, cfm_pkg::REG_CTRL, i);
      bus(1'b0, cfm_pkg::REG_CTRL, 0);
      chk("ctrl", q, i);
    end
    avs_byteenable <= 4'hE;
    bus(1'b1, cfm_pkg::REG_CTRL, 3);
    avs_byteenable <= 4'hF;
    bus(1'b0, cfm_pkg::REG_CTRL, 0);
    chk("ctrl be", q, 0);
  endtask
  task automatic t_mains(logic [1:0] sel, int n);
    bus(1'b1, cfm_pkg::REG_CTRL, 32'(sel));
    mains_ok <= 1'b0;
    cyc(5);
    chk("leds", {mains_led, fault_led, load1_led}, 3);
    cyc(n * 100 - 110);
    chk("early", {mains_loss_relay, fault_relay}, 3);
    cyc(115);
    chk("late", {mains_loss_relay, fault_relay}, 0);
    chk("panel", {mains_alarm, collective_alarm}, 3);
    bus(1'b0, cfm_pkg::REG_STATUS, 0);
    chk("status mains", q[1:0], 3);
    mains_ok <= 1'b1;
    cyc(5);
    chk("back", {mains_loss_relay, fault_relay, mains_led}, 7);
  endtask
  task automatic t_faults();
    int i;
    int bits[12] = '{4, 3, 6, 6, 10, 11, 12, 5, 5, 8, 9, 9};
    for (i = 0; i < 12; i++) begin
      apply(i, 1'b1);
      cyc(6);
      chk("relay on", fault_relay, 0);
      bus(1'b0, cfm_pkg::REG_STATUS, 0);
      chk("status bit", q[bits[i]], 1);
      apply(i, 1'b0);
      cyc(6);
      chk("relay off", fault_relay, 1);
    end
  endtask
  task automatic t_overload();
    overload <= 1'b1;
    cyc(5);
    chk("limit on", charge_limit, 1);
    overload <= 1'b0;
    cyc(5400);
    chk("limit held", charge_limit, 1);
    cyc(700);
    chk("limit off", charge_limit, 0);
  endtask
  task automatic t_addon();
    int k;
    int n;
    seq_start <= 1'b1;
    for (k = 1; k <= 8; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (ch_on === 8'((1 << (k - 1)) - 1) && n < 40);
      chk("ch_on", ch_on, (1 << k) - 1);
      if (k > 1) chk("gap", n, 10);
    end
    ch_fuse_ok <= 8'hF7;
    cyc(5);
    chk("fuse", {ch_green_led, addon_red_led, addon_relay}, 10'h3DE);
    chk("fuse relay", fault_relay, 0);
    ch_fuse_ok <= 8'hFF;
    seq_start  <= 1'b0;
    cyc(5);
    chk("ch off", ch_on, 0);
  endtask
  task automatic wait_relay(logic v);
    int n;
    n = 0;
    while (fault_relay !== v && n < 30500) begin
      @(posedge mclk);
      n++;
    end
    chk("battery relay", fault_relay, v);
  endtask
  task automatic t_battery();
    battery_continuity_ok <= 1'b0;
    wait_relay(1'b0);
    bus(1'b0, cfm_pkg::REG_STATUS, 0);
    chk("battery bit", q[2], 1);
    battery_continuity_ok <= 1'b1;
    wait_relay(1'b1);
  endtask

  initial begin
    cyc(12);
    rstn <= 1'b1;
    cyc(10);
    t_regs();
    t_mains(2'h0, 10);
    t_mains(2'h1, 60);
    t_faults();
    t_overload();
    t_addon();
    t_battery();
    finish_test();
  end
  initial begin
    cyc(95000);
    num_errors++;
    finish_test();
  end
endmodule
